/* logic/pam_defines.svh */
// register offsets, field positions and reset values of the pin mux
`ifndef PAM_DEFINES_SVH
`define PAM_DEFINES_SVH
`define PAM_OFS_SWITCH 8'h00
`define PAM_OFS_PF1 8'h04
`define PAM_OFS_FUNC2 8'h08
`define PAM_OFS_FUNCALL 8'h0C
`define PAM_OFS_CLK 8'h10
`define PAM_OFS_PM1 8'h14
`define PAM_OFS_MODE2 8'h18
`define PAM_OFS_PMX 8'h1C
`define PAM_OFS_LAT1 8'h20
`define PAM_OFS_ANA 8'h24
`define PAM_OFS_LCD 8'h28
`define PAM_OFS_STAT 8'h2C
`define PAM_SW_IRQ0 0
`define PAM_SW_CAP0 1
`define PAM_SW_T52 2
`define PAM_SW_RELA 4
`define PAM_SW_RELB 5
`define PAM_FSEL_P13 3
`define PAM_P11 1
`define PAM_P12 2
`define PAM_P13 3
`define PAM_CLK_SUB 4
`define PAM_CLK_MAIN 6
`define PAM_CLK_EXT 7
`define PAM_PMX_P33 0
`define PAM_PMX_P40 1
`define PAM_PMX_P120 2
`define PAM_CHSEL_LSB 8
`define PAM_LCD_QBIAS 0
`define PAM_RST_ZERO 32'h0000_0000
`define PAM_RST_PM 8'hFF
`define PAM_RST_CLK 8'h00
`define PAM_RST_PMX 3'h7
`define PAM_RST_MODE2 6'h3F
`define PAM_RST_P12 4'hF
`endif

/* logic/pam_pkg.sv */
// types shared by the port alternate function mux
package pam_pkg;
    typedef struct packed {
        logic val;
        logic oe_n;
    } pam_drive_t;
    typedef struct packed {
        logic main_osc;
        logic ext_clk;
        logic sub_osc;
        logic debug_pins;
    } pam_clkpin_t;
endpackage

/* logic/pam_mux.sv */
// port alternate function mux with apb register access
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`include "pam_defines.svh"
module pam_mux import pam_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic p11_pin_in,
    input wire logic p12_pin_in,
    input wire logic p13_pin_in,
    input wire logic p33_pin_in,
    input wire logic p40_pin_in,
    input wire logic p120_pin_in,
    input wire logic debug_active_in,
    input wire logic serial_clock_ten_in,
    input wire logic serial_out_ten_in,
    input wire logic primary_uart_transmit_in,
    input wire logic secondary_uart_transmit_in,
    input wire logic high_speed_timer_two_in,
    output pam_drive_t p11_drive_out,
    output pam_drive_t p13_drive_out,
    output logic serial_clock_ten_out,
    output logic key_input_four_out,
    output logic secondary_uart_receive_out,
    output logic timer_capture_input_zero_out,
    output logic external_irq_zero_out,
    output logic timer52_count_enable_out,
    output logic key_interrupt_input_zero_out,
    output logic display_bias_voltage_input_out,
    output logic [5:0] display_segment_enable_out,
    output logic [5:0] analog_input_enable_out,
    output logic [5:0] analog_input_channel_out,
    output logic [2:0] segment_group_enable_out,
    output pam_clkpin_t clock_pin_out,
    output logic [3:0] p12_port_input_out
);

    logic [5:0] input_switch_control_reg;
    logic port1_bit3_function_select_reg;
    logic [5:0] port2_function_reg;
    logic [2:0] all_port_function_reg;
    logic [7:0] clock_pin_mode_select_reg;
    logic [7:0] port1_mode_reg;
    logic [5:0] port2_mode_reg;
    logic [2:0] misc_mode_reg;
    logic [7:0] port1_latch_reg;
    logic [5:0] analog_port_configuration_reg;
    logic [2:0] analog_channel_select_reg;
    logic quarter_bias_reg;
    logic pready_reg;
    logic [31:0] rdata_next;
    logic wr_fire;
    logic rd_take;

    logic uart_reloc;
    logic rxd_next;
    logic [5:0] ana_en_next;
    pam_clkpin_t clk_next;

    // offsets that answer without a slave error
    function automatic logic map_ok(input logic [7:0] a);
        case (a)
            `PAM_OFS_SWITCH, `PAM_OFS_PF1, `PAM_OFS_FUNC2, `PAM_OFS_FUNCALL,
            `PAM_OFS_CLK, `PAM_OFS_PM1, `PAM_OFS_MODE2, `PAM_OFS_PMX,
            `PAM_OFS_LAT1, `PAM_OFS_ANA, `PAM_OFS_LCD, `PAM_OFS_STAT: map_ok = 1'b1;
            default: map_ok = 1'b0;
        endcase
    endfunction

    // mode bit is the output enable; the latch either gates or merges the peripheral
    function automatic pam_drive_t alt_drive(input logic pm, input logic lat,
                                             input logic alt, input logic gate_one);
        pam_drive_t d;
        d.oe_n = pm;
        d.val = gate_one ? (lat & alt) : (lat | alt);
        alt_drive = d;
    endfunction

    // one wait state: pready rises on the second access cycle
    // writes land only on the edge that shows pready; a request held past it writes again two cycles later
    assign wr_fire = psel_in & penable_in & pready_reg & pwrite_in;
    assign rd_take = psel_in & penable_in & ~pready_reg;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_reg <= 1'b0;
            prdata_out <= `PAM_RST_ZERO;
            pslverr_out <= 1'b0;
        end else begin
            pready_reg <= rd_take;
            if (rd_take) begin
                prdata_out <= pwrite_in ? `PAM_RST_ZERO : rdata_next;
                pslverr_out <= ~map_ok(paddr_in);
            end
        end
    end
    assign pready_out = pready_reg;

    always_comb begin
        rdata_next = `PAM_RST_ZERO;
        case (paddr_in)
            `PAM_OFS_SWITCH: rdata_next[5:0] = input_switch_control_reg;
            `PAM_OFS_PF1: rdata_next[`PAM_FSEL_P13] = port1_bit3_function_select_reg;
            `PAM_OFS_FUNC2: rdata_next[5:0] = port2_function_reg;
            `PAM_OFS_FUNCALL: rdata_next[2:0] = all_port_function_reg;
            `PAM_OFS_CLK: rdata_next[7:0] = clock_pin_mode_select_reg;
            `PAM_OFS_PM1: rdata_next[7:0] = port1_mode_reg;
            `PAM_OFS_MODE2: rdata_next[5:0] = port2_mode_reg;
            `PAM_OFS_PMX: rdata_next[2:0] = misc_mode_reg;
            `PAM_OFS_LAT1: rdata_next[7:0] = port1_latch_reg;
            `PAM_OFS_ANA: begin
                rdata_next[5:0] = analog_port_configuration_reg;
                rdata_next[`PAM_CHSEL_LSB +: 3] = analog_channel_select_reg;
            end
            `PAM_OFS_LCD: rdata_next[`PAM_LCD_QBIAS] = quarter_bias_reg;
            `PAM_OFS_STAT: rdata_next[15:0] = {clock_pin_out, p12_port_input_out,
                display_bias_voltage_input_out, key_interrupt_input_zero_out,
                timer52_count_enable_out, external_irq_zero_out,
                timer_capture_input_zero_out, secondary_uart_receive_out,
                p13_drive_out.oe_n, p11_drive_out.oe_n};
            default: rdata_next = `PAM_RST_ZERO;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            input_switch_control_reg <= 6'h00;
            port1_bit3_function_select_reg <= 1'b0;
            port2_function_reg <= 6'h00;
            all_port_function_reg <= 3'h0;
            // clock pins start as port inputs
            clock_pin_mode_select_reg <= `PAM_RST_CLK;
            port1_mode_reg <= `PAM_RST_PM;
            port2_mode_reg <= `PAM_RST_MODE2;
            misc_mode_reg <= `PAM_RST_PMX;
            port1_latch_reg <= 8'h00;
            analog_port_configuration_reg <= 6'h00;
            analog_channel_select_reg <= 3'h0;
            quarter_bias_reg <= 1'b0;
        end else if (wr_fire) begin
            case (paddr_in)
                `PAM_OFS_SWITCH: input_switch_control_reg <= pwdata_in[5:0];
                `PAM_OFS_PF1: port1_bit3_function_select_reg <= pwdata_in[`PAM_FSEL_P13];
                `PAM_OFS_FUNC2: port2_function_reg <= pwdata_in[5:0];
                `PAM_OFS_FUNCALL: all_port_function_reg <= pwdata_in[2:0];
                `PAM_OFS_CLK: clock_pin_mode_select_reg <= pwdata_in[7:0];
                `PAM_OFS_PM1: port1_mode_reg <= pwdata_in[7:0];
                `PAM_OFS_MODE2: port2_mode_reg <= pwdata_in[5:0];
                `PAM_OFS_PMX: misc_mode_reg <= pwdata_in[2:0];
                `PAM_OFS_LAT1: port1_latch_reg <= pwdata_in[7:0];
                `PAM_OFS_ANA: begin
                    analog_port_configuration_reg <= pwdata_in[5:0];
                    analog_channel_select_reg <= pwdata_in[`PAM_CHSEL_LSB +: 3];
                end
                `PAM_OFS_LCD: quarter_bias_reg <= pwdata_in[`PAM_LCD_QBIAS];
                default: ;
            endcase
        end
    end

    // relocated uart lines need bit four low and bit five high
    assign uart_reloc = ~input_switch_control_reg[`PAM_SW_RELA]
                      & input_switch_control_reg[`PAM_SW_RELB];
    // idle high when not routed, so a uart never sees a false start bit
    assign rxd_next = (uart_reloc & port1_mode_reg[`PAM_P12]) ? p12_pin_in : 1'b1;

    // analog use needs function 0, configuration and mode bit set
    assign ana_en_next = ~port2_function_reg & analog_port_configuration_reg & port2_mode_reg;

    // oscillator pins connect only after their mode is set
    always_comb begin
        clk_next.debug_pins = debug_active_in;
        // debug takes the main oscillator pins
        clk_next.main_osc = clock_pin_mode_select_reg[`PAM_CLK_MAIN]
                          & ~clock_pin_mode_select_reg[`PAM_CLK_EXT] & ~debug_active_in;
        clk_next.ext_clk = clock_pin_mode_select_reg[`PAM_CLK_MAIN]
                         & clock_pin_mode_select_reg[`PAM_CLK_EXT] & ~debug_active_in;
        clk_next.sub_osc = clock_pin_mode_select_reg[`PAM_CLK_SUB];
    end

    // uart and serial pins of port 1
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            p11_drive_out <= '{val: 1'b0, oe_n: 1'b1};
            p13_drive_out <= '{val: 1'b0, oe_n: 1'b1};
            serial_clock_ten_out <= 1'b0;
            key_input_four_out <= 1'b0;
            secondary_uart_receive_out <= 1'b1;
        end else begin
            // serial clock out needs latch 1, serial data out latch 0
            p11_drive_out <= alt_drive(port1_mode_reg[`PAM_P11], port1_latch_reg[`PAM_P11],
                                       serial_clock_ten_in, 1'b1);
            serial_clock_ten_out <= port1_mode_reg[`PAM_P11] & p11_pin_in;
            // function select picks port or uart transmit
            if (port1_bit3_function_select_reg) begin
                p13_drive_out.oe_n <= port1_mode_reg[`PAM_P13];
                p13_drive_out.val <= uart_reloc ? secondary_uart_transmit_in
                                                : primary_uart_transmit_in;
            end else begin
                p13_drive_out <= alt_drive(port1_mode_reg[`PAM_P13],
                                           port1_latch_reg[`PAM_P13], serial_out_ten_in, 1'b0);
            end
            key_input_four_out <= ~port1_bit3_function_select_reg
                                & port1_mode_reg[`PAM_P13] & p13_pin_in;
            secondary_uart_receive_out <= rxd_next;
        end
    end

    // input switch routing to timers and interrupts
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_capture_input_zero_out <= 1'b0;
            external_irq_zero_out <= 1'b0;
            timer52_count_enable_out <= 1'b1;
        end else begin
            timer_capture_input_zero_out <= input_switch_control_reg[`PAM_SW_CAP0] ? rxd_next
                : (misc_mode_reg[`PAM_PMX_P33] & p33_pin_in);
            external_irq_zero_out <= input_switch_control_reg[`PAM_SW_IRQ0] ? rxd_next
                : (misc_mode_reg[`PAM_PMX_P120] & p120_pin_in);
            // timer two gates the count input
            timer52_count_enable_out <= ~input_switch_control_reg[`PAM_SW_T52]
                                      | high_speed_timer_two_in;
        end
    end

    // display, key, analog and clock pins
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_interrupt_input_zero_out <= 1'b0;
            display_bias_voltage_input_out <= 1'b0;
            display_segment_enable_out <= 6'h00;
            analog_input_enable_out <= 6'h00;
            analog_input_channel_out <= 6'h00;
            segment_group_enable_out <= 3'h0;
            clock_pin_out <= '{main_osc: 1'b0, ext_clk: 1'b0, sub_osc: 1'b0, debug_pins: 1'b0};
            p12_port_input_out <= `PAM_RST_P12;
        end else begin
            // quarter bias claims port 4 bit 0
            display_bias_voltage_input_out <= quarter_bias_reg;
            key_interrupt_input_zero_out <= ~quarter_bias_reg
                                          & misc_mode_reg[`PAM_PMX_P40] & p40_pin_in;
            // each function register steers its own port
            display_segment_enable_out <= port2_function_reg;
            segment_group_enable_out <= all_port_function_reg;
            analog_input_enable_out <= ana_en_next;
            // channel decode outside 0..5 selects no pin
            analog_input_channel_out <= ana_en_next & 6'(7'h01 << analog_channel_select_reg);
            clock_pin_out <= clk_next;
            p12_port_input_out <= {~clk_next.sub_osc, ~clk_next.sub_osc,
                ~(clk_next.main_osc | clk_next.ext_clk | clk_next.debug_pins),
                ~(clk_next.main_osc | clk_next.debug_pins)};
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_capture_rx_route: assert property (
        input_switch_control_reg[`PAM_SW_CAP0] |=> timer_capture_input_zero_out == $past(rxd_next))
        else $error("capture input not fed from uart receive");
    a_irq_rx_route: assert property (
        input_switch_control_reg[`PAM_SW_IRQ0] |=> external_irq_zero_out == $past(rxd_next))
        else $error("irq zero not fed from uart receive");
    a_timer_gate_off: assert property (
        !input_switch_control_reg[`PAM_SW_T52] |=> timer52_count_enable_out)
        else $error("count input gated while switch clear");
    a_bias_pin_claim: assert property (
        quarter_bias_reg |=> display_bias_voltage_input_out && !key_interrupt_input_zero_out)
        else $error("key input active under quarter bias");
    a_p13_uart_tx: assert property (
        port1_bit3_function_select_reg && !uart_reloc
        |=> p13_drive_out.val == $past(primary_uart_transmit_in))
        else $error("port 1 bit 3 not carrying uart transmit");
    a_clock_mode_gate: assert property (
        clock_pin_out.main_osc |-> $past(clock_pin_mode_select_reg[`PAM_CLK_MAIN]))
        else $error("oscillator connected without mode");
    a_rx_relocate: assert property (
        !uart_reloc |=> secondary_uart_receive_out)
        else $error("uart receive routed without relocation");
    a_debug_pins_take: assert property (
        debug_active_in |=> clock_pin_out.debug_pins && !clock_pin_out.main_osc
        && !p12_port_input_out[0])
        else $error("debug pins not taken");
    a_p2_channel_sel: assert property (
        (analog_input_channel_out & ~analog_input_enable_out) == 6'h00)
        else $error("channel on a non analog pin");
    a_p2_seg_analog: assert property (
        (display_segment_enable_out & analog_input_enable_out) == 6'h00)
        else $error("pin both segment and analog");
    a_sck_latch_gate: assert property (
        !port1_latch_reg[`PAM_P11] |=> !p11_drive_out.val)
        else $error("serial clock drives with latch low");
    a_p13_reloc_tx: assert property (
        port1_bit3_function_select_reg && uart_reloc
        |=> p13_drive_out.val == $past(secondary_uart_transmit_in))
        else $error("port 1 bit 3 not carrying relocated transmit");
    a_sck_in_mode: assert property (
        !port1_mode_reg[`PAM_P11] |=> !serial_clock_ten_out)
        else $error("serial clock input taken from an output pin");
    a_sub_osc_gate: assert property (
        clock_pin_out.sub_osc |-> $past(clock_pin_mode_select_reg[`PAM_CLK_SUB]))
        else $error("subsystem oscillator connected without mode");
    a_timer_gate_on: assert property (
        input_switch_control_reg[`PAM_SW_T52]
        |=> timer52_count_enable_out == $past(high_speed_timer_two_in))
        else $error("count input not gated by timer two");
    a_irq_pin_route: assert property (
        !input_switch_control_reg[`PAM_SW_IRQ0]
        |=> external_irq_zero_out == $past(misc_mode_reg[`PAM_PMX_P120] & p120_pin_in))
        else $error("irq zero not fed from its own pin");

    c_rx_to_capture: cover property (
        uart_reloc && input_switch_control_reg[`PAM_SW_CAP0] && rxd_next == 1'b0);
    c_debug_take: cover property (clock_pin_out.debug_pins);
    c_ext_clock: cover property (clock_pin_out.ext_clk);
    c_analog_pick: cover property (analog_input_channel_out != 6'h00);
    c_bus_error: cover property (pready_out && pslverr_out);

endmodule

/* tb/pam_far_model.sv */
// far side model: package pins and peripheral levels around the mux
`timescale 1ns/100ps
module pam_far_model import pam_pkg::*; (
    input wire logic [10:0] level_in,
    input wire pam_drive_t p11_drive_in,
    input wire pam_drive_t p13_drive_in,
    output logic p11_pin_out,
    output logic p12_pin_out,
    output logic p13_pin_out,
    output logic p33_pin_out,
    output logic p40_pin_out,
    output logic p120_pin_out,
    output logic [4:0] periph_out
);
    // two-way pins: mux wins while its enable is low, else the board level shows
    assign p11_pin_out = p11_drive_in.oe_n ? level_in[10] : p11_drive_in.val;
    assign p13_pin_out = p13_drive_in.oe_n ? level_in[8] : p13_drive_in.val;
    assign p12_pin_out = level_in[9];
    assign p33_pin_out = level_in[7];
    assign p40_pin_out = level_in[6];
    assign p120_pin_out = level_in[5];
    // peripherals: sck, so, tx0, tx6, timer two
    assign periph_out = level_in[4:0];
endmodule

/* tb/tb_port_alternate_function_mux.sv */
// self-checking bench for the port alternate function mux
`timescale 1ns/100ps
`include "pam_defines.svh"
module tb_port_alternate_function_mux import pam_pkg::*;;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic dbg = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [10:0] lv = 11'h000;
    logic [31:0] prdata, rdq;
    logic pready, pslverr, erq;
    logic p11, p12, p13, p33, p40, p120;
    logic [4:0] per;
    pam_drive_t d11, d13;
    logic sck_o, key4, rx, cap, irq0, t52, key0, bias;
    logic [5:0] seg, ana, chn;
    logic [2:0] grp;
    pam_clkpin_t cp;
    logic [3:0] p12p;
    int err_total = 0;
    int checks = 0;
    // reset values, last entry is the status word with all pins low
    logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h3F, 32'h7,
        32'h0, 32'h0, 32'h0, 32'hF27};

    initial begin
        forever #5 mclk = ~mclk;
    end

    pam_far_model pam_far_model_i (.level_in(lv), .p11_drive_in(d11), .p13_drive_in(d13),
        .p11_pin_out(p11), .p12_pin_out(p12), .p13_pin_out(p13), .p33_pin_out(p33),
        .p40_pin_out(p40), .p120_pin_out(p120), .periph_out(per));

    pam_mux pam_mux_i (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .p11_pin_in(p11), .p12_pin_in(p12), .p13_pin_in(p13), .p33_pin_in(p33),
        .p40_pin_in(p40), .p120_pin_in(p120), .debug_active_in(dbg),
        .serial_clock_ten_in(per[4]), .serial_out_ten_in(per[3]),
        .primary_uart_transmit_in(per[2]), .secondary_uart_transmit_in(per[1]),
        .high_speed_timer_two_in(per[0]), .p11_drive_out(d11), .p13_drive_out(d13),
        .serial_clock_ten_out(sck_o), .key_input_four_out(key4),
        .secondary_uart_receive_out(rx), .timer_capture_input_zero_out(cap),
        .external_irq_zero_out(irq0), .timer52_count_enable_out(t52),
        .key_interrupt_input_zero_out(key0), .display_bias_voltage_input_out(bias),
        .display_segment_enable_out(seg), .analog_input_enable_out(ana),
        .analog_input_channel_out(chn), .segment_group_enable_out(grp),
        .clock_pin_out(cp), .p12_port_input_out(p12p));

    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdq = prdata;
        erq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk({31'h0, pready}, 32'h1);
            tally_and_finish();
        end
    endtask

    task automatic settle;
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        settle();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdq, exp);
        chk({31'h0, erq}, {31'h0, e});
    endtask

    task automatic set_lv(input logic [10:0] v);
        @(posedge mclk);
        lv <= v;
        settle();
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
    endtask

    initial begin
        do_reset();
        for (int i = 0; i < 12; i++) begin
            rd(8'(4 * i), rv[i], 1'b0);
        end
        // unmapped offset is refused and a write there changes nothing
        wr(8'h30, 32'hFFFF_FFFF);
        chk({31'h0, erq}, 32'h1);
        rd(8'h30, 32'h0, 1'b1);
        chk({28'h0, p12p}, 32'hF);
        chk({28'h0, cp}, 32'h0);
        chk({28'h0, d11, d13}, 32'h5);
        // relocated receive line feeds capture input zero
        set_lv(11'h200);
        wr(`PAM_OFS_SWITCH, 32'h22);
        chk({31'h0, rx}, 32'h1);
        chk({31'h0, cap}, 32'h1);
        set_lv(11'h0A0);
        chk({31'h0, rx}, 32'h0);
        chk({31'h0, cap}, 32'h0);
        chk({31'h0, irq0}, 32'h1);
        wr(`PAM_OFS_SWITCH, 32'h21);
        chk({31'h0, cap}, 32'h1);
        chk({31'h0, irq0}, 32'h0);
        wr(`PAM_OFS_SWITCH, 32'h31);
        chk({31'h0, rx}, 32'h1);
        // timer two gating of the timer fifty-two count input
        set_lv(11'h000);
        wr(`PAM_OFS_SWITCH, 32'h04);
        chk({31'h0, t52}, 32'h0);
        set_lv(11'h001);
        chk({31'h0, t52}, 32'h1);
        // p13 output functions: serial out, then each uart transmit
        wr(`PAM_OFS_PM1, 32'hF5);
        set_lv(11'h008);
        chk({30'h0, d13}, 32'h2);
        wr(`PAM_OFS_PF1, 32'h08);
        set_lv(11'h004);
        chk({30'h0, d13}, 32'h2);
        wr(`PAM_OFS_SWITCH, 32'h20);
        chk({30'h0, d13}, 32'h0);
        set_lv(11'h002);
        chk({30'h0, d13}, 32'h2);
        // serial clock output needs the latch at 1
        set_lv(11'h010);
        wr(`PAM_OFS_LAT1, 32'h02);
        chk({30'h0, d11}, 32'h2);
        wr(`PAM_OFS_LAT1, 32'h00);
        chk({30'h0, d11}, 32'h0);
        // inputs once the mode bits are back at 1
        wr(`PAM_OFS_PM1, 32'hFF);
        wr(`PAM_OFS_PF1, 32'h00);
        set_lv(11'h540);
        chk({30'h0, d13}, 32'h1);
        chk({30'h0, key4, sck_o}, 32'h3);
        chk({30'h0, key0, bias}, 32'h2);
        wr(`PAM_OFS_LCD, 32'h01);
        chk({30'h0, key0, bias}, 32'h1);
        // port 2 and the all-port select each keep to their own pins
        wr(`PAM_OFS_ANA, 32'h33F);
        wr(`PAM_OFS_FUNC2, 32'h15);
        wr(`PAM_OFS_FUNCALL, 32'h05);
        chk({26'h0, seg}, 32'h15);
        chk({29'h0, grp}, 32'h5);
        chk({26'h0, ana}, 32'h2A);
        chk({26'h0, chn}, 32'h08);
        // clock pin modes and debug takeover
        wr(`PAM_OFS_CLK, 32'h40);
        chk({24'h0, cp, p12p}, 32'h8C);
        wr(`PAM_OFS_CLK, 32'h10);
        chk({24'h0, cp, p12p}, 32'h23);
        wr(`PAM_OFS_CLK, 32'hC0);
        chk({31'h0, cp.ext_clk}, 32'h1);
        wr(`PAM_OFS_CLK, 32'h40);
        @(posedge mclk);
        dbg <= 1'b1;
        settle();
        chk({28'h0, cp}, 32'h1);
        // second reset in mid-run clears the configuration
        @(posedge mclk);
        dbg <= 1'b0;
        do_reset();
        settle();
        chk({28'h0, d11, d13}, 32'h5);
        rd(`PAM_OFS_SWITCH, 32'h0, 1'b0);
        rd(`PAM_OFS_PM1, 32'hFF, 1'b0);
        rd(`PAM_OFS_CLK, 32'h0, 1'b0);
        tally_and_finish();
    end
endmodule
